// >>> dmc_bus_mem.sv
// system bus memory model: answers each word with a pattern of its address
module dmc_bus_mem (
    // clock, reset, pace
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        slow_i,
    // system bus
    input  wire logic        req_i,
    input  wire logic        wr_i,
    input  wire logic [31:0] addr_i,
    output logic             ack_o,
    output logic [31:0]      rdata_o,
    // tallies of answered words
    output logic [7:0]       n_rd_o,
    output logic [7:0]       n_wr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_cnt;  // wait states spent on the current word
    // one-cycle answer per word; data flips between answers so stale data never looks valid
    always @(posedge clk_i)
    begin
        ack_o <= 1'b0;
        rdata_o <= ~rdata_o;
        if (rst_i)
        begin
            wait_cnt <= 2'h0;
            rdata_o <= 32'h0;
            n_rd_o <= 8'h0;
            n_wr_o <= 8'h0;
        end
        else if (req_i && !ack_o)
        begin
            if (wait_cnt == (slow_i ? 2'h3 : 2'h0))
            begin
                ack_o <= 1'b1;
                wait_cnt <= 2'h0;
                rdata_o <= {addr_i[31:2], 2'h0} ^ 32'h5A5A_0000;
                if (wr_i)
                    n_wr_o <= n_wr_o + 8'h1;
                else
                    n_rd_o <= n_rd_o + 8'h1;
            end
            else
                wait_cnt <= wait_cnt + 2'h1;
        end
    end
endmodule

// >>> dmc_cache.v
// 2-Kbyte direct-mapped cache controller with write-through data side
`include "dmc_defs.vh"

// Notes on behaviour
// RULE1 - instruction-only, data-only or split half-and-half
// RULE2 - supervisor writes setup register selecting organization
// RULE3 - direct-mapped, 128 lines of 16 bytes
// RULE4 - 128 tags, data array 512 x 32
// RULE5 - parallel lookup; split uses bit nine, fetch/operand
// RULE6 - hit returns array word in one cycle
// RULE7 - tag mismatch fetches whole 16-byte line
// RULE8 - fill buffer collects incoming line words
// RULE9 - data caching is write-through
// RULE10 - every operand write goes to bus
// RULE11 - valid bits cleared at reset
// RULE12 - write hit updates word; write miss no allocate
module dmc_cache (
    // clock, reset, enable
    input  wire        REF_CLK_I,
    input  wire        RST_I,
    input  wire        CE_I,
    // setup register write port and readback
    input  wire        SETUP_WR_I,
    input  wire        SETUP_SUPER_I,
    input  wire [1:0]  SETUP_ORG_I,
    output wire [1:0]  SETUP_ORG_O,
    // core local bus
    input  wire        CORE_REQ_I,
    input  wire        CORE_FETCH_I,
    input  wire        CORE_WR_I,
    input  wire [31:0] CORE_ADDR_I,
    input  wire [31:0] CORE_WDATA_I,
    input  wire [3:0]  CORE_BE_I,
    output wire        CORE_READY_O,
    output wire        CORE_ACK_O,
    output wire        CORE_HIT_O,
    output wire [31:0] CORE_RDATA_O,
    // system bus
    output wire        BUS_REQ_O,
    output wire        BUS_WR_O,
    output wire [31:0] BUS_ADDR_O,
    output wire [31:0] BUS_WDATA_O,
    output wire [3:0]  BUS_BE_O,
    input  wire        BUS_ACK_I,
    input  wire [31:0] BUS_RDATA_I
);

    // storage arrays
    reg  [`DMC_TAG_W-1:0]   tag_mem  [0:`DMC_LINES-1];  // address tags
    reg  [31:0]             data_mem [0:`DMC_WORDS-1];  // line data
    reg  [`DMC_LINES-1:0]   valid;                      // per-line valid bits

    // control state
    reg  [`DMC_ORG_W-1:0]   org;                 // active organization
    reg  [`DMC_ST_W-1:0]    state;               // controller state
    reg  [`DMC_WSEL_W-1:0]  cnt;                 // word counter in a line
    reg  [31:0]             r_addr;              // latched request address
    reg  [`DMC_TIDX_W-1:0]  r_tidx;              // latched tag index
    reg  [31:0]             rdata;               // read data to the core
    reg                     ack;                 // one-cycle completion
    reg                     hit;                 // completion came from array
    reg  [31:0]             bus_addr;            // system bus address
    reg  [31:0]             bus_wdata;           // system bus write data
    reg  [3:0]              bus_be;              // system bus byte enables

    // lookup signals
    reg  [`DMC_TIDX_W-1:0]  tidx;                // tag index of request
    reg  [`DMC_WIDX_W-1:0]  widx;                // data word index of request
    wire                    cacheable;           // request side is cached
    wire                    lookup_hit;          // valid tag matches
    wire                    take;                // request accepted now
    wire [31:0]             fill_word;           // word out of fill buffer
    wire [`DMC_WSEL_W-1:0]  fill_sel;            // fill buffer read select
    wire                    fill_clear;          // start a new line
    wire                    fill_load;           // bus word arrives in fill

    // index select: split mode forces the top index bit by access kind
    always @*
    begin
        if (org == `DMC_ORG_SPLIT)
        begin
            tidx = {!CORE_FETCH_I, CORE_ADDR_I[`DMC_SIDX_MSB:`DMC_LINE_LSB]};  // RULE5
            widx = {!CORE_FETCH_I, CORE_ADDR_I[`DMC_SIDX_MSB:`DMC_WORD_LSB]};  // RULE5
        end
        else
        begin
            tidx = CORE_ADDR_I[`DMC_UIDX_MSB:`DMC_LINE_LSB];                   // RULE5
            widx = CORE_ADDR_I[`DMC_UIDX_MSB:`DMC_WORD_LSB];                   // RULE5
        end
    end

    // which side the current organization caches
    assign cacheable = CORE_FETCH_I ?
                       (org == `DMC_ORG_INSTR || org == `DMC_ORG_SPLIT) :
                       (org == `DMC_ORG_DATA  || org == `DMC_ORG_SPLIT);     // RULE1

    // tag compare runs alongside the data array read
    assign lookup_hit = cacheable && valid[tidx] &&
                        (tag_mem[tidx] == CORE_ADDR_I[31:`DMC_TAG_LSB]);    // RULE3

    // requests are taken only while idle; a setup write holds them off
    assign take = CE_I && CORE_REQ_I && (state == `DMC_ST_IDLE) && !SETUP_WR_I;
    // fill buffer control; the line copy starts one word past the requested one
    assign fill_clear = take;
    assign fill_load  = (state == `DMC_ST_FILL) && BUS_ACK_I;
    assign fill_sel   = (state == `DMC_ST_LINE) ? cnt + r_addr[3:2] + `DMC_WSEL_ONE : r_addr[3:2];

    dmc_fill_buf u_fill (
        .clk_i   (REF_CLK_I),
        .rst_i   (RST_I),
        .ce_i    (CE_I),
        .clear_i (fill_clear),
        .load_i  (fill_load),
        .data_i  (BUS_RDATA_I),
        .sel_i   (fill_sel),
        .data_o  (fill_word),
        .full_o  ()
    );

    // setup register; user-level writes are dropped without effect
    always @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            org <= `DMC_ORG_RESET;
        end
        else if (CE_I && SETUP_WR_I && SETUP_SUPER_I && state == `DMC_ST_IDLE)
        begin
            org <= SETUP_ORG_I;                  // RULE2
        end
    end

    // valid bits and tags: reset and organization change both invalidate,
    // because index mapping differs between unified and split
    always @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            valid <= {`DMC_LINES{1'b0}};         // RULE11
        end
        else if (CE_I)
        begin
            if (SETUP_WR_I && SETUP_SUPER_I && state == `DMC_ST_IDLE)
            begin
                valid <= {`DMC_LINES{1'b0}};
            end
            else if (state == `DMC_ST_LINE && cnt == `DMC_LAST_WORD)
            begin
                valid[r_tidx]   <= 1'b1;                        // RULE7
                tag_mem[r_tidx] <= r_addr[31:`DMC_TAG_LSB];     // RULE4
            end
        end
    end

    // data array: write hits merge bytes, line fills copy the buffer
    integer b;
    always @(posedge REF_CLK_I)
    begin
        if (CE_I)
        begin
            if (take && CORE_WR_I && lookup_hit)
            begin
                for (b = 0; b < 4; b = b + 1)
                begin
                    if (CORE_BE_I[b])
                    begin
                        data_mem[widx][b*8 +: 8] <= CORE_WDATA_I[b*8 +: 8];  // RULE12
                    end
                end
            end
            else if (state == `DMC_ST_LINE)
            begin
                data_mem[{r_tidx, fill_sel}] <= fill_word;    // RULE4
            end
        end
    end

    // controller: hit reads finish next edge, everything else uses the bus
    always @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            state     <= `DMC_ST_IDLE;
            cnt       <= `DMC_WSEL_ZERO;
            r_addr    <= 32'h00000000;
            r_tidx    <= {`DMC_TIDX_W{1'b0}};
            rdata     <= 32'h00000000;
            ack       <= 1'b0;
            hit       <= 1'b0;
            bus_addr  <= 32'h00000000;
            bus_wdata <= 32'h00000000;
            bus_be    <= 4'h0;
        end
        else if (CE_I)
        begin
            ack <= 1'b0;
            hit <= 1'b0;
            case (state)
                `DMC_ST_IDLE:
                begin
                    if (take)
                    begin
                        r_addr <= CORE_ADDR_I;
                        r_tidx <= tidx;
                        cnt    <= `DMC_WSEL_ZERO;
                        if (CORE_WR_I)
                        begin
                            // write-through: the bus sees every write
                            state     <= `DMC_ST_WRITE;              // RULE10
                            bus_addr  <= CORE_ADDR_I;                // RULE9
                            bus_wdata <= CORE_WDATA_I;
                            bus_be    <= CORE_BE_I;
                        end
                        else if (lookup_hit)
                        begin
                            rdata <= data_mem[widx];                 // RULE6
                            ack   <= 1'b1;                           // RULE6
                            hit   <= 1'b1;
                        end
                        else if (cacheable)
                        begin
                            // line-aligned fill from word zero
                            state    <= `DMC_ST_FILL;                // RULE7
                            bus_addr <= {CORE_ADDR_I[31:`DMC_LINE_LSB], `DMC_LINE_OFS};
                            bus_be   <= 4'hF;
                        end
                        else
                        begin
                            state    <= `DMC_ST_SINGLE;
                            bus_addr <= CORE_ADDR_I;
                            bus_be   <= 4'hF;
                        end
                    end
                end
                `DMC_ST_FILL:
                begin
                    if (BUS_ACK_I)
                    begin
                        cnt      <= cnt + `DMC_WSEL_ONE;
                        bus_addr <= {bus_addr[31:`DMC_LINE_LSB], cnt + `DMC_WSEL_ONE,
                                     `DMC_BYTE_OFS};                 // RULE7
                        if (cnt == `DMC_LAST_WORD)
                        begin
                            state <= `DMC_ST_LINE;
                        end
                    end
                end
                `DMC_ST_LINE:
                begin
                    // one word per cycle moves from buffer into array
                    cnt <= cnt + `DMC_WSEL_ONE;
                    if (cnt == `DMC_LAST_WORD)
                    begin
                        state <= `DMC_ST_IDLE;
                        rdata <= fill_word;                          // RULE8
                        ack   <= 1'b1;
                    end
                end
                `DMC_ST_SINGLE:
                begin
                    if (BUS_ACK_I)
                    begin
                        state <= `DMC_ST_IDLE;
                        rdata <= BUS_RDATA_I;
                        ack   <= 1'b1;
                    end
                end
                `DMC_ST_WRITE:
                begin
                    if (BUS_ACK_I)
                    begin
                        state <= `DMC_ST_IDLE;
                        ack   <= 1'b1;                               // RULE10
                    end
                end
                default:
                begin
                    state <= `DMC_ST_IDLE;
                end
            endcase
        end
    end

    // outputs; the line copy ends on the requested word, which rdata takes
    assign SETUP_ORG_O  = org;
    assign CORE_READY_O = (state == `DMC_ST_IDLE) && !SETUP_WR_I;
    assign CORE_ACK_O   = ack;
    assign CORE_HIT_O   = hit;
    assign CORE_RDATA_O = rdata;
    assign BUS_REQ_O    = (state == `DMC_ST_FILL) || (state == `DMC_ST_SINGLE) ||
                          (state == `DMC_ST_WRITE);
    assign BUS_WR_O     = (state == `DMC_ST_WRITE);
    assign BUS_ADDR_O   = bus_addr;
    assign BUS_WDATA_O  = bus_wdata;
    assign BUS_BE_O     = bus_be;

endmodule

// >>> dmc_cache_props.sv
// concurrent checks on the ports of the direct-mapped cache
`include "dmc_defs.vh"
module dmc_cache_props (
    // clock, reset, enable
    input wire logic        REF_CLK_I,
    input wire logic        RST_I,
    input wire logic        CE_I,
    // setup register port
    input wire logic        SETUP_WR_I,
    input wire logic        SETUP_SUPER_I,
    input wire logic [1:0]  SETUP_ORG_I,
    input wire logic [1:0]  SETUP_ORG_O,
    // core local bus
    input wire logic        CORE_REQ_I,
    input wire logic        CORE_FETCH_I,
    input wire logic        CORE_WR_I,
    input wire logic [31:0] CORE_ADDR_I,
    input wire logic [31:0] CORE_WDATA_I,
    input wire logic [3:0]  CORE_BE_I,
    input wire logic        CORE_READY_O,
    input wire logic        CORE_ACK_O,
    input wire logic        CORE_HIT_O,
    input wire logic [31:0] CORE_RDATA_O,
    // system bus
    input wire logic        BUS_REQ_O,
    input wire logic        BUS_WR_O,
    input wire logic [31:0] BUS_ADDR_O,
    input wire logic [31:0] BUS_WDATA_O,
    input wire logic [3:0]  BUS_BE_O,
    input wire logic        BUS_ACK_I,
    input wire logic [31:0] BUS_RDATA_I
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    // a request is taken only while the controller shows ready
    wire take = CE_I && CORE_REQ_I && CORE_READY_O;
    // last word of a line fill answered by the bus
    sequence s_fill_last;
        BUS_REQ_O && !BUS_WR_O && BUS_ACK_I && BUS_ADDR_O[3:2] == `DMC_LAST_WORD;
    endsequence
    // bus request still waiting for its answer
    sequence s_bus_wait;
        CE_I && BUS_REQ_O && !BUS_ACK_I;
    endsequence
    chk_reset_state: assert property ($fell(RST_I) |-> SETUP_ORG_O == `DMC_ORG_RESET && CORE_READY_O && !BUS_REQ_O)
        else $error("state after reset is wrong");
    chk_hit_single: assert property (CORE_HIT_O |-> CORE_ACK_O && $past(take && !CORE_WR_I))
        else $error("hit not one cycle after a read take");
    chk_write_issue: assert property (take && CORE_WR_I |=> BUS_REQ_O && BUS_WR_O
        && BUS_ADDR_O == $past(CORE_ADDR_I) && BUS_WDATA_O == $past(CORE_WDATA_I) && BUS_BE_O == $past(CORE_BE_I))
        else $error("operand write not sent to bus");
    chk_bus_hold: assert property (s_bus_wait |=> BUS_REQ_O && $stable(BUS_ADDR_O) && $stable(BUS_WR_O))
        else $error("bus request dropped before answer");
    chk_write_done: assert property (CE_I && BUS_REQ_O && BUS_WR_O && BUS_ACK_I |=> CORE_ACK_O && !BUS_REQ_O)
        else $error("write not completed after bus answer");
    chk_fill_step: assert property (CE_I && BUS_REQ_O && !BUS_WR_O && BUS_ACK_I
        && BUS_ADDR_O[3:2] != `DMC_LAST_WORD |=> !BUS_REQ_O || BUS_ADDR_O == $past(BUS_ADDR_O) + 32'h4)
        else $error("line fill address did not step by one word");
    chk_fill_done: assert property (s_fill_last |-> ##[1:6] CORE_ACK_O)
        else $error("no completion after last fill word");
    chk_setup_user: assert property (SETUP_WR_I && !SETUP_SUPER_I |=> $stable(SETUP_ORG_O))
        else $error("user write changed the organization");
    chk_ready_block: assert property (SETUP_WR_I || BUS_REQ_O |-> !CORE_READY_O)
        else $error("ready shown while busy");
endmodule
bind dmc_cache dmc_cache_props dmc_cache_props_i (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .CE_I(CE_I),
    .SETUP_WR_I(SETUP_WR_I), .SETUP_SUPER_I(SETUP_SUPER_I), .SETUP_ORG_I(SETUP_ORG_I), .SETUP_ORG_O(SETUP_ORG_O),
    .CORE_REQ_I(CORE_REQ_I), .CORE_FETCH_I(CORE_FETCH_I), .CORE_WR_I(CORE_WR_I), .CORE_ADDR_I(CORE_ADDR_I),
    .CORE_WDATA_I(CORE_WDATA_I), .CORE_BE_I(CORE_BE_I), .CORE_READY_O(CORE_READY_O), .CORE_ACK_O(CORE_ACK_O),
    .CORE_HIT_O(CORE_HIT_O), .CORE_RDATA_O(CORE_RDATA_O), .BUS_REQ_O(BUS_REQ_O), .BUS_WR_O(BUS_WR_O),
    .BUS_ADDR_O(BUS_ADDR_O), .BUS_WDATA_O(BUS_WDATA_O), .BUS_BE_O(BUS_BE_O), .BUS_ACK_I(BUS_ACK_I),
    .BUS_RDATA_I(BUS_RDATA_I));

// >>> dmc_cache_tb.sv
// self-checking bench for the direct-mapped cache
`include "dmc_defs.vh"
module dmc_cache_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        setup_wr = 1'b0;
    logic        setup_super = 1'b0;
    logic [1:0]  setup_org = 2'h0;
    logic        req = 1'b0;
    logic        fetch = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  be = 4'hF;     // byte enables of operand writes
    logic        slow = 1'b0;   // stretches bus answers to four cycles
    wire  [1:0]  org;
    wire         ready, ack, hit, bus_req, bus_wr, bus_ack;
    wire  [31:0] rdata, bus_addr, bus_wdata, bus_rdata;
    wire  [3:0]  bus_be;
    wire  [7:0]  n_rd, n_wr;
    int          err_total = 0;
    int          n_compared = 0;
    int          cycles = 0;
    always #2.5 clk = ~clk;
    // clock enable held on: every cycle counts
    dmc_cache dmc_cache_i (.REF_CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .SETUP_WR_I(setup_wr),
        .SETUP_SUPER_I(setup_super), .SETUP_ORG_I(setup_org), .SETUP_ORG_O(org), .CORE_REQ_I(req),
        .CORE_FETCH_I(fetch), .CORE_WR_I(wr), .CORE_ADDR_I(addr), .CORE_WDATA_I(wdata), .CORE_BE_I(be),
        .CORE_READY_O(ready), .CORE_ACK_O(ack), .CORE_HIT_O(hit), .CORE_RDATA_O(rdata), .BUS_REQ_O(bus_req),
        .BUS_WR_O(bus_wr), .BUS_ADDR_O(bus_addr), .BUS_WDATA_O(bus_wdata), .BUS_BE_O(bus_be),
        .BUS_ACK_I(bus_ack), .BUS_RDATA_I(bus_rdata));
    dmc_bus_mem dmc_bus_mem_i (.clk_i(clk), .rst_i(rst), .slow_i(slow), .req_i(bus_req), .wr_i(bus_wr),
        .addr_i(bus_addr), .ack_o(bus_ack), .rdata_o(bus_rdata), .n_rd_o(n_rd), .n_wr_o(n_wr));
    function automatic logic [31:0] pat(input logic [31:0] a);
        return {a[31:2], 2'h0} ^ 32'h5A5A_0000;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one setup write strobe, then let the new code land
    task automatic set_org(input logic sup, input logic [1:0] code);
        @(negedge clk);
        setup_wr = 1'b1;
        setup_super = sup;
        setup_org = code;
        @(negedge clk);
        setup_wr = 1'b0;
        @(negedge clk);
    endtask
    // request held until ready, then wait for completion under a bound
    task automatic access(input logic f, input logic w, input logic [31:0] a, input logic [31:0] d,
                          output logic [31:0] got, output logic got_hit, output int lat);
        int n;
        @(negedge clk);
        req = 1'b1;
        fetch = f;
        wr = w;
        addr = a;
        wdata = d;
        n = 0;
        while (ready !== 1'b1 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        req = 1'b0;
        lat = 1;
        while (ack !== 1'b1 && lat < 60)
        begin
            @(negedge clk);
            lat++;
        end
        check({31'h0, ack}, 32'h1);
        got = rdata;
        got_hit = hit;
    endtask
    // read and judge data, hit flag and single-cycle answer on hits
    task automatic rd(input logic f, input logic [31:0] a, input logic exp_hit);
        logic [31:0] got;
        logic        h;
        int          lat;
        access(f, 1'b0, a, 32'h0, got, h, lat);
        check(got, pat(a));
        check({31'h0, h}, {31'h0, exp_hit});
        if (exp_hit)
            check(32'(lat), 32'h1);
    endtask
    task automatic t_setup;
        @(negedge clk);
        check({30'h0, org}, {30'h0, `DMC_ORG_RESET});
        rd(1'b1, 32'h2040, 1'b0);
        rd(1'b1, 32'h2040, 1'b0);
        set_org(1'b0, `DMC_ORG_DATA);
        check({30'h0, org}, {30'h0, `DMC_ORG_RESET});
        for (int c = 0; c < 3; c++)
        begin
            set_org(1'b1, c[1:0]);
            check({30'h0, org}, {30'h0, c[1:0]});
        end
    endtask
    task automatic t_data_side;
        logic [7:0] r0;
        set_org(1'b1, `DMC_ORG_DATA);
        r0 = n_rd;
        rd(1'b0, 32'h1234, 1'b0);
        check({24'h0, n_rd - r0}, 32'h4);
        rd(1'b0, 32'h1234, 1'b1);
        rd(1'b0, 32'h1238, 1'b1);
        rd(1'b0, 32'h1A34, 1'b0);
        rd(1'b0, 32'h1234, 1'b0);
        rd(1'b1, 32'h1234, 1'b0);
    endtask
    task automatic t_write_through;
        logic [31:0] got;
        logic        h;
        int          lat;
        logic [7:0]  w0;
        w0 = n_wr;
        access(1'b0, 1'b1, 32'h1234, 32'hC0DE_0001, got, h, lat);
        access(1'b0, 1'b0, 32'h1234, 32'h0, got, h, lat);
        check(got, 32'hC0DE_0001);
        check({31'h0, h}, 32'h1);
        be = 4'h3;
        access(1'b0, 1'b1, 32'h1234, 32'hFFFF_BEEF, got, h, lat);
        be = 4'hF;
        access(1'b0, 1'b0, 32'h1234, 32'h0, got, h, lat);
        check(got, 32'hC0DE_BEEF);
        slow = 1'b1;
        access(1'b0, 1'b1, 32'h3000, 32'hC0DE_0002, got, h, lat);
        slow = 1'b0;
        check({24'h0, n_wr - w0}, 32'h3);
        rd(1'b0, 32'h3000, 1'b0);
    endtask
    task automatic t_split;
        set_org(1'b1, `DMC_ORG_SPLIT);
        rd(1'b1, 32'h2040, 1'b0);
        rd(1'b0, 32'h4040, 1'b0);
        rd(1'b1, 32'h2040, 1'b1);
        rd(1'b0, 32'h4040, 1'b1);
        rd(1'b0, 32'h4440, 1'b0);
        rd(1'b0, 32'h4040, 1'b0);
    endtask
    task automatic t_instr_only;
        logic [7:0] r0;
        set_org(1'b1, `DMC_ORG_INSTR);
        rd(1'b1, 32'h2040, 1'b0);
        rd(1'b1, 32'h2040, 1'b1);
        r0 = n_rd;
        rd(1'b0, 32'h2040, 1'b0);
        check({24'h0, n_rd - r0}, 32'h1);
    endtask
    // a hang counts as a mismatch
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_setup();
        t_data_side();
        t_write_through();
        t_split();
        t_instr_only();
        report_and_stop();
    end
endmodule

// >>> dmc_defs.vh
// constants shared by the direct-mapped cache and its line fill buffer
`ifndef DMC_DEFS_VH
`define DMC_DEFS_VH

// organization select codes held in the setup register
`define DMC_ORG_W        2
`define DMC_ORG_INSTR    2'h0
`define DMC_ORG_DATA     2'h1
`define DMC_ORG_SPLIT    2'h2
`define DMC_ORG_OFF      2'h3
`define DMC_ORG_RESET    2'h3

// geometry: 128 lines of 16 bytes, 512 words of 32 bits
`define DMC_LINES        128
`define DMC_WORDS        512
`define DMC_LINE_WORDS   4
`define DMC_TIDX_W       7
`define DMC_WIDX_W       9
`define DMC_WSEL_W       2
`define DMC_TAG_W        22
`define DMC_TAG_LSB      10
`define DMC_UIDX_MSB     10
`define DMC_SIDX_MSB     9
`define DMC_LINE_LSB     4
`define DMC_WORD_LSB     2
`define DMC_LAST_WORD    2'h3
`define DMC_WSEL_ONE     2'h1
`define DMC_WSEL_ZERO    2'h0
`define DMC_BYTE_OFS     2'h0
`define DMC_LINE_OFS     4'h0

// controller states
`define DMC_ST_W         3
`define DMC_ST_IDLE      3'h0
`define DMC_ST_FILL      3'h1
`define DMC_ST_LINE      3'h2
`define DMC_ST_SINGLE    3'h3
`define DMC_ST_WRITE     3'h4

`endif

// >>> dmc_fill_buf.v
// line fill buffer: collects the four words of a missed line
`include "dmc_defs.vh"

module dmc_fill_buf (
    // clock, reset, enable
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    // load side
    input  wire        clear_i,
    input  wire        load_i,
    input  wire [31:0] data_i,
    // read side
    input  wire [1:0]  sel_i,
    output wire [31:0] data_o,
    output wire        full_o
);

    reg  [`DMC_WSEL_W-1:0] slot;                 // next slot to fill
    reg                    full;                 // all four words present
    wire [31:0]            word [0:`DMC_LINE_WORDS-1];

    // slot pointer and full flag; clear wins so a new miss starts clean
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            slot <= `DMC_WSEL_ZERO;
            full <= 1'b0;
        end
        else if (ce_i)
        begin
            if (clear_i)
            begin
                slot <= `DMC_WSEL_ZERO;
                full <= 1'b0;
            end
            else if (load_i)
            begin
                slot <= slot + `DMC_WSEL_ONE;
                full <= (slot == `DMC_LAST_WORD);
            end
        end
    end

    // one storage word per generate entry; words arrive in address order
    genvar g;
    generate
        for (g = 0; g < `DMC_LINE_WORDS; g = g + 1)
        begin : gen_word
            reg [31:0] store;                    // one 32-bit word of the line
            always @(posedge clk_i)
            begin
                if (ce_i && load_i && !clear_i && slot == g)
                begin
                    store <= data_i;             // RULE8
                end
            end
            assign word[g] = store;
        end
    endgenerate

    assign data_o = word[sel_i];
    assign full_o = full;

endmodule
